// ### shared/link_cap_consts.svh
`ifndef LINK_CAP_CONSTS_SVH
`define LINK_CAP_CONSTS_SVH

// configuration byte offsets of the dword registers
`define LCR_ADDR_W 8
`define LCR_CAP_OFFSET 8'h9c
`define LCR_CTRL_OFFSET 8'ha0

// link capabilities field positions
`define LCR_CAP_UPPER_LSB 18
`define LCR_CAP_L1_MSB 17
`define LCR_CAP_L1_LSB 15
`define LCR_CAP_L0S_MSB 14
`define LCR_CAP_L0S_LSB 12
`define LCR_CAP_ASPM_MSB 11
`define LCR_CAP_ASPM_LSB 10
`define LCR_CAP_WIDTH_MSB 9
`define LCR_CAP_WIDTH_LSB 4
`define LCR_CAP_SPEED_MSB 3
`define LCR_CAP_SPEED_LSB 0

// link capabilities constant field values
`define LCR_ASPM_SUPPORT 2'h3
`define LCR_MAX_LINK_WIDTH 6'h01
`define LCR_MAX_LINK_SPEED 4'h1

// link control field positions
`define LCR_CTRL_CLKREQ_BIT 8
`define LCR_CTRL_EXT_SYNC_BIT 7
`define LCR_CTRL_COMMON_CLK_BIT 6
`define LCR_CTRL_RETRAIN_BIT 5
`define LCR_CTRL_DISABLE_BIT 4
`define LCR_CTRL_ASPM_MSB 1
`define LCR_CTRL_ASPM_LSB 0
`define LCR_CTRL_RESET 16'h0000
`define LCR_CTRL_LANES 2

// active-state policy codes
`define LCR_ASPM_OFF 2'h0
`define LCR_ASPM_L0S 2'h1
`define LCR_ASPM_RSVD 2'h2
`define LCR_ASPM_BOTH 2'h3

// l1 exit sequencing and clock-request delay adjustment
`define LCR_FTS_NORMAL 8'h20
`define LCR_FTS_EXTENDED 8'hff
`define LCR_EP_L1_STEP 3'h2
`define LCR_EP_L1_MAX 3'h7

`endif

// ### shared/link_cap_pkg.sv
package link_cap_pkg;
    typedef logic [2:0] exit_time_t;
    typedef logic [1:0] aspm_policy_t;
    typedef logic [7:0] fts_count_t;
    typedef logic [15:0] ctrl_word_t;
    typedef logic [31:0] cfg_word_t;
endpackage

// ### src/link_cap_word.sv
`timescale 1ns/1ps
`default_nettype none
`include "link_cap_consts.svh"

// assembles the read-only link capabilities dword
module link_cap_word (
    input wire logic [13:0] i_cap_upper,
    input wire link_cap_pkg::exit_time_t i_pm_l1_exit_time,
    input wire link_cap_pkg::exit_time_t i_pm_l0s_exit_time,
    output link_cap_pkg::cfg_word_t o_cap_word
);
    wire link_cap_pkg::exit_time_t l1_exit_time_cap;
    wire link_cap_pkg::exit_time_t l0s_exit_time_cap;
    wire link_cap_pkg::aspm_policy_t aspm_support;
    wire [5:0] max_link_width;
    wire [3:0] max_link_speed;

    // latencies track the pm latency register live
    assign l1_exit_time_cap = i_pm_l1_exit_time;
    assign l0s_exit_time_cap = i_pm_l0s_exit_time;
    assign aspm_support = `LCR_ASPM_SUPPORT;
    assign max_link_width = `LCR_MAX_LINK_WIDTH;
    assign max_link_speed = `LCR_MAX_LINK_SPEED;

    // pack the fields at their positions
    always_comb begin
        o_cap_word = '0;
        o_cap_word[31:`LCR_CAP_UPPER_LSB] = i_cap_upper;
        o_cap_word[`LCR_CAP_L1_MSB:`LCR_CAP_L1_LSB] = l1_exit_time_cap;
        o_cap_word[`LCR_CAP_L0S_MSB:`LCR_CAP_L0S_LSB] = l0s_exit_time_cap;
        o_cap_word[`LCR_CAP_ASPM_MSB:`LCR_CAP_ASPM_LSB] = aspm_support;
        o_cap_word[`LCR_CAP_WIDTH_MSB:`LCR_CAP_WIDTH_LSB] = max_link_width;
        o_cap_word[`LCR_CAP_SPEED_MSB:`LCR_CAP_SPEED_LSB] = max_link_speed;
    end
endmodule // link_cap_word

`default_nettype wire

// ### src/downstream_link_cap_ctrl_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "link_cap_consts.svh"

module downstream_link_cap_ctrl_regs (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // configuration access port
    input wire logic i_cfg_rd,
    input wire logic i_cfg_wr,
    input wire logic [`LCR_ADDR_W-1:0] i_cfg_addr,
    input wire logic [3:0] i_cfg_be,
    input wire link_cap_pkg::cfg_word_t i_cfg_wdata,
    output link_cap_pkg::cfg_word_t o_cfg_rdata,
    output logic o_cfg_ack,
    // fields held elsewhere in the port
    input wire logic [13:0] i_cap_upper,
    input wire link_cap_pkg::exit_time_t i_pm_l1_exit_time,
    input wire link_cap_pkg::exit_time_t i_pm_l0s_exit_time,
    input wire link_cap_pkg::exit_time_t i_endpoint_l1_base,
    // controls toward the link logic
    output link_cap_pkg::exit_time_t o_endpoint_l1_delay,
    output logic o_clock_request_enable,
    output logic o_extended_sync,
    output link_cap_pkg::fts_count_t o_l1_exit_fts_count,
    output logic o_l1_exit_extra_ts2,
    output logic o_common_clock,
    output logic o_retrain_link,
    output logic o_link_disable,
    output link_cap_pkg::aspm_policy_t o_aspm_policy,
    output logic o_l0s_entry_en,
    output logic o_l1_entry_en
);
    // dword address match, used for both registers
    function automatic logic addr_hit(
        input logic [`LCR_ADDR_W-1:0] addr,
        input logic [`LCR_ADDR_W-1:0] offs
    );
        addr_hit = (addr[`LCR_ADDR_W-1:2] == offs[`LCR_ADDR_W-1:2]);
    endfunction

    // reset image of the control word, sliced per stored field
    localparam link_cap_pkg::ctrl_word_t ctrl_reset = `LCR_CTRL_RESET;

    // stored control bits
    logic clock_request_enable_r;
    logic extended_sync_r;
    logic common_clock_r;
    logic link_disable_r;
    link_cap_pkg::aspm_policy_t aspm_policy_r;
    logic clock_request_enable_nxt;
    logic extended_sync_nxt;
    logic common_clock_nxt;
    logic link_disable_nxt;
    link_cap_pkg::aspm_policy_t aspm_policy_nxt;

    link_cap_pkg::cfg_word_t rdata_r;
    link_cap_pkg::cfg_word_t rdata_nxt;
    logic ack_r;

    wire link_cap_pkg::cfg_word_t cap_word;
    wire link_cap_pkg::ctrl_word_t ctrl_word;
    wire hit_cap;
    wire hit_ctrl;
    wire ctrl_wr;
    wire [`LCR_CTRL_LANES-1:0] lane_wr;
    wire [3:0] ep_sum;

    // capabilities word assembly
    link_cap_word u_cap_word (
        .i_cap_upper(i_cap_upper),
        .i_pm_l1_exit_time(i_pm_l1_exit_time),
        .i_pm_l0s_exit_time(i_pm_l0s_exit_time),
        .o_cap_word(cap_word)
    );

    // address decode and write lanes
    assign hit_cap = addr_hit(i_cfg_addr, `LCR_CAP_OFFSET);
    assign hit_ctrl = addr_hit(i_cfg_addr, `LCR_CTRL_OFFSET);
    assign ctrl_wr = i_cfg_wr & hit_ctrl;

    genvar g;
    generate
        for (g = 0; g < `LCR_CTRL_LANES; g = g + 1) begin : g_lane
            assign lane_wr[g] = ctrl_wr & i_cfg_be[g];
        end
    endgenerate

    // next values of the stored control bits
    assign clock_request_enable_nxt = lane_wr[1] ?
        i_cfg_wdata[`LCR_CTRL_CLKREQ_BIT] : clock_request_enable_r;
    assign extended_sync_nxt = lane_wr[0] ?
        i_cfg_wdata[`LCR_CTRL_EXT_SYNC_BIT] : extended_sync_r;
    assign common_clock_nxt = lane_wr[0] ?
        i_cfg_wdata[`LCR_CTRL_COMMON_CLK_BIT] : common_clock_r;
    assign link_disable_nxt = lane_wr[0] ?
        i_cfg_wdata[`LCR_CTRL_DISABLE_BIT] : link_disable_r;
    assign aspm_policy_nxt = lane_wr[0] ?
        i_cfg_wdata[`LCR_CTRL_ASPM_MSB:`LCR_CTRL_ASPM_LSB] :
        aspm_policy_r;

    // control register storage; reserved bits have no flops
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            clock_request_enable_r <= ctrl_reset[`LCR_CTRL_CLKREQ_BIT];
            extended_sync_r <= ctrl_reset[`LCR_CTRL_EXT_SYNC_BIT];
            common_clock_r <= ctrl_reset[`LCR_CTRL_COMMON_CLK_BIT];
            link_disable_r <= ctrl_reset[`LCR_CTRL_DISABLE_BIT];
            aspm_policy_r <=
                ctrl_reset[`LCR_CTRL_ASPM_MSB:`LCR_CTRL_ASPM_LSB];
        end else begin
            clock_request_enable_r <= clock_request_enable_nxt;
            extended_sync_r <= extended_sync_nxt;
            common_clock_r <= common_clock_nxt;
            link_disable_r <= link_disable_nxt;
            aspm_policy_r <= aspm_policy_nxt;
        end
    end

    // control read view: 15:9, retrain, 3 and 2 read zero
    assign ctrl_word = {7'h00,
                        clock_request_enable_r,
                        extended_sync_r,
                        common_clock_r,
                        1'b0,
                        link_disable_r,
                        2'h0,
                        aspm_policy_r};

    // read data select; unmapped offsets read zero
    always_comb begin
        rdata_nxt = '0;
        if (hit_cap) begin
            rdata_nxt = cap_word;
        end else if (hit_ctrl) begin
            rdata_nxt = {16'h0000, ctrl_word};
        end
    end

    // registered read data and access acknowledge
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_r <= '0;
            ack_r <= 1'b0;
        end else begin
            rdata_r <= i_cfg_rd ? rdata_nxt : rdata_r;
            ack_r <= i_cfg_rd | i_cfg_wr;
        end
    end

    assign o_cfg_rdata = rdata_r;
    assign o_cfg_ack = ack_r;

    // retrain is a pulse in the write cycle, never stored
    assign o_retrain_link = lane_wr[0] &
        i_cfg_wdata[`LCR_CTRL_RETRAIN_BIT];

    // endpoint l1 delay is the base plus one step while clock request is on, saturating
    assign ep_sum = {1'b0, i_endpoint_l1_base} + {1'b0, `LCR_EP_L1_STEP};
    assign o_endpoint_l1_delay = !clock_request_enable_r ?
        i_endpoint_l1_base :
        (ep_sum[3] ? `LCR_EP_L1_MAX : ep_sum[2:0]);

    // l1 exit training sequence selection
    assign o_l1_exit_fts_count = extended_sync_r ?
        `LCR_FTS_EXTENDED : `LCR_FTS_NORMAL;
    assign o_l1_exit_extra_ts2 = extended_sync_r;

    // active-state policy decode; reserved code enables nothing
    assign o_l0s_entry_en = (aspm_policy_r == `LCR_ASPM_L0S) |
        (aspm_policy_r == `LCR_ASPM_BOTH);
    assign o_l1_entry_en = (aspm_policy_r == `LCR_ASPM_BOTH);

    assign o_clock_request_enable = clock_request_enable_r;
    assign o_extended_sync = extended_sync_r;
    assign o_common_clock = common_clock_r;
    assign o_link_disable = link_disable_r;
    assign o_aspm_policy = aspm_policy_r;
endmodule // downstream_link_cap_ctrl_regs

`default_nettype wire

// ### sim/link_cap_checker.sv
`timescale 1ns/1ps
`default_nettype none
// watches config accesses and the link controls
module link_cap_checker (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_cfg_rd,
    input wire logic i_cfg_wr,
    input wire logic [7:0] i_cfg_addr,
    input wire logic [3:0] i_cfg_be,
    input wire link_cap_pkg::cfg_word_t i_cfg_wdata,
    input wire link_cap_pkg::cfg_word_t o_cfg_rdata,
    input wire logic o_cfg_ack,
    input wire link_cap_pkg::exit_time_t i_pm_l1_exit_time,
    input wire link_cap_pkg::fts_count_t o_l1_exit_fts_count,
    input wire logic o_extended_sync,
    input wire logic o_l1_exit_extra_ts2,
    input wire logic o_retrain_link,
    input wire logic o_link_disable,
    input wire link_cap_pkg::aspm_policy_t o_aspm_policy,
    input wire logic o_l0s_entry_en,
    input wire logic o_l1_entry_en
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);
    // dword decode of the two registers
    wire logic cap_rd = i_cfg_rd && i_cfg_addr[7:2] == 6'h27;
    wire logic ctl_rd = i_cfg_rd && i_cfg_addr[7:2] == 6'h28;
    wire logic ctl_wr = i_cfg_wr && i_cfg_addr[7:2] == 6'h28;
    ack_follow_a: assert property (o_cfg_ack == $past(i_cfg_rd || i_cfg_wr))
        else $error("ack not one cycle after request");
    retrain_pulse_a: assert property (
        o_retrain_link == (ctl_wr && i_cfg_be[0] && i_cfg_wdata[5]))
        else $error("retrain pulse wrong");
    cap_l1_a: assert property (
        cap_rd |=> o_cfg_rdata[17:15] == $past(i_pm_l1_exit_time))
        else $error("l1 exit field not mirrored");
    cap_const_a: assert property (
        cap_rd |=> o_cfg_rdata[11:0] == 12'hc11)
        else $error("capability constants wrong");
    ctrl_rsvd_a: assert property (
        ctl_rd |=> o_cfg_rdata[31:9] == 23'h0 && !o_cfg_rdata[5])
        else $error("control reserved or retrain bits set");
    disable_wr_a: assert property (
        ctl_wr && i_cfg_be[0] |=> o_link_disable == $past(i_cfg_wdata[4]))
        else $error("link disable not written");
    ext_sync_a: assert property (
        o_l1_exit_fts_count == (o_extended_sync ? 8'hff : 8'h20)
        && o_l1_exit_extra_ts2 == o_extended_sync)
        else $error("l1 exit sequencing wrong");
    policy_en_a: assert property (
        o_l0s_entry_en == o_aspm_policy[0]
        && o_l1_entry_en == (o_aspm_policy == 2'h3))
        else $error("policy enables wrong");
endmodule // link_cap_checker
bind downstream_link_cap_ctrl_regs link_cap_checker chk (.*);
`default_nettype wire

// ### sim/link_side_model.sv
`timescale 1ns/1ps
`default_nettype none
// link logic stand-in: counts retrains, latencies move per retrain
module link_side_model (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_retrain,
    output link_cap_pkg::exit_time_t o_l1,
    output link_cap_pkg::exit_time_t o_l0s,
    output int o_retrains
);
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_l1 <= 3'h5;
            o_l0s <= 3'h2;
            o_retrains <= 0;
        end else if (i_retrain) begin
            o_l1 <= o_l1 + 3'h1;
            o_l0s <= o_l0s - 3'h1;
            o_retrains <= o_retrains + 1;
        end
    end
endmodule // link_side_model
`default_nettype wire

// ### sim/downstream_link_cap_ctrl_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module downstream_link_cap_ctrl_regs_test;
    localparam logic [13:0] CAPU = 14'h0a5b;
    logic clk = 0, rst_n = 0, rd = 0, wr = 0;
    logic [7:0] addr = 8'h00;
    logic [3:0] be = 4'h0;
    logic [31:0] wd = 32'h0, rdo, ex;
    logic [2:0] l1, l0s, dly;
    logic [7:0] fts;
    logic [1:0] pol;
    logic ack, cre, es, ts2, cc, rl, ld, l0e, l1e;
    int rt, err_total = 0, checked = 0, cyc = 0;
    downstream_link_cap_ctrl_regs uut (.i_mclk(clk), .i_rst_n(rst_n),
        .i_cfg_rd(rd), .i_cfg_wr(wr), .i_cfg_addr(addr), .i_cfg_be(be),
        .i_cfg_wdata(wd), .o_cfg_rdata(rdo), .o_cfg_ack(ack),
        .i_cap_upper(CAPU), .i_pm_l1_exit_time(l1),
        .i_pm_l0s_exit_time(l0s), .i_endpoint_l1_base(3'h6),
        .o_endpoint_l1_delay(dly), .o_clock_request_enable(cre),
        .o_extended_sync(es), .o_l1_exit_fts_count(fts),
        .o_l1_exit_extra_ts2(ts2), .o_common_clock(cc),
        .o_retrain_link(rl), .o_link_disable(ld), .o_aspm_policy(pol),
        .o_l0s_entry_en(l0e), .o_l1_entry_en(l1e));
    link_side_model peer (.i_mclk(clk), .i_rst_n(rst_n),
        .i_retrain(rl), .o_l1(l1), .o_l0s(l0s), .o_retrains(rt));
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic cmp(input string nm, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [3:0] b,
        input logic [31:0] d);
        @(negedge clk);
        wr = 1;
        addr = a;
        be = b;
        wd = d;
        @(negedge clk);
        wr = 0;
        cmp("ack", 1, ack);
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a,
        input logic [31:0] e);
        @(negedge clk);
        rd = 1;
        addr = a;
        @(negedge clk);
        rd = 0;
        cmp("ack", 1, ack);
        cmp(nm, e, rdo);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            err_total++;
            wrap_up;
        end
    end
    initial begin
        repeat (2) @(negedge clk);
        rst_n = 1;
        cmp("fts", 8'h20, fts);
        cmp("clkreq", 0, cre);
        cmp("delay", 6, dly);
        cmp("retrain", 0, rl);
        rd_chk("ctrl", 8'ha0, 32'h0);
        ex = {CAPU, l1, l0s, 12'hc11};
        rd_chk("cap", 8'h9c, ex);
        rd_chk("unmapped", 8'h10, 32'h0);
        $display("test reset done");
        // every bit written, retrain fired once
        wr_reg(8'ha0, 4'hf, 32'hffff_ffff);
        rd_chk("ctrl", 8'ha0, 32'h1d3);
        cmp("retrains", 1, rt);
        cmp("clkreq", 1, cre);
        cmp("delay", 7, dly);
        cmp("fts", 8'hff, fts);
        cmp("ts2", 1, ts2);
        cmp("ext_sync", 1, es);
        cmp("common", 1, cc);
        cmp("disable", 1, ld);
        ex = {CAPU, l1, l0s, 12'hc11};
        rd_chk("cap", 8'h9c, ex);
        $display("test full write done");
        // each policy code through lane 0 only
        for (int c = 0; c < 4; c++) begin
            wr_reg(8'ha0, 4'h1, c);
            rd_chk("ctrl", 8'ha0, 32'h100 | c);
            cmp("policy", c, pol);
            cmp("l0s_en", c[0], l0e);
            cmp("l1_en", c == 3, l1e);
        end
        cmp("fts", 8'h20, fts);
        cmp("disable", 0, ld);
        cmp("retrains", 1, rt);
        $display("test policy done");
        // clock request off, capability write ignored
        wr_reg(8'ha0, 4'h2, 32'h0);
        cmp("delay", 6, dly);
        wr_reg(8'h9c, 4'hf, 32'h0);
        rd_chk("cap", 8'h9c, ex);
        $display("test clkreq off done");
        wrap_up;
    end
endmodule // downstream_link_cap_ctrl_regs_test
`default_nettype wire
